// ==== hw/sru_consts.svh ====
// sru_consts.svh: register offsets, field positions, reset values and timing counts
// assumes: included by the SPI register/shift unit files and by its assertion and test files
`ifndef SRU_CONSTS_SVH
`define SRU_CONSTS_SVH

// register offsets on the 8-bit register port
`define SRU_CH0_CONTROL 8'hB6
`define SRU_CH0_FLAGS 8'hB7
`define SRU_CH0_DATA 8'hB8
`define SRU_CH1_CONTROL 8'hBA
`define SRU_CH1_FLAGS 8'hBB
`define SRU_CH1_DATA 8'hBC

// control_reg fields
`define SRU_CTL_IRQ_EN 7
`define SRU_CTL_SPI_EN 5
`define SRU_CTL_MASTER 4
`define SRU_CTL_CPOL 3
`define SRU_CTL_CPHA 2
`define SRU_CTL_RESET 8'h04

// flags_reg fields
`define SRU_FLG_DONE 7
`define SRU_FLG_WRITE_COLLISION_FLAG 6
`define SRU_FLG_MODE_FAULT_FLAG 4

// serial clock half period in system clocks (stands in for the baud divider)
`define SRU_HALF_PERIOD 8'h04
`define SRU_LAST_BIT 3'h7
`define SRU_ZERO_BYTE 8'h00

`endif

// ==== hw/sru_pkg.sv ====
// sru_pkg.sv: types shared by the SPI register/shift unit
// assumes: nothing beyond the constants header
package sru_pkg;

  // serial pins seen from outside, raw and unsynchronised
  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic ssN;
  } sru_link_in_t;

  // serial pin drivers; enables are low while driving
  typedef struct packed {
    logic sckOut;
    logic sckOeN;
    logic mosiOut;
    logic mosiOeN;
    logic misoOut;
    logic misoOeN;
  } sru_link_out_t;

  typedef enum logic {
    SRU_IDLE,
    SRU_RUN
  } sru_master_t;

  // all state of one channel
  typedef struct packed {
    logic irqEn;
    logic spiEn;
    logic master;
    logic cpol;
    logic cpha;
    logic done;
    logic write_collision_flag;
    logic mode_fault_flag;
    logic [7:0] shifter;
    logic [7:0] rxBuf;
    logic [2:0] bitCnt;
    sru_master_t mst;
    logic [7:0] divCnt;
    logic sckOut;
    logic outBit;
    logic sampleBit;
    logic [3:0] syncA;
    logic [3:0] syncB;
    logic prevSck;
  } sru_chan_t;

  typedef struct packed {
    logic [7:0] rdata;
  } sru_top_t;

endpackage : sru_pkg

// ==== hw/sru_top.sv ====
// sru_top.sv: two-channel SPI register and shift unit with its register port
// assumes: a cpu on clk drives the register port; serial pins arrive from
// outside the clock domain and are synchronised here
`timescale 1ns/10ps
`include "sru_consts.svh"

// one SPI channel: control, flags, shifter and receive buffer
module sru_channel (
  input wire logic clk,
  input wire logic reset,
  input wire logic ctrlWr,
  input wire logic dataWr,
  input wire logic flagsRd,
  input wire logic [7:0] wdata,
  input wire sru_pkg::sru_link_in_t linkIn,
  output sru_pkg::sru_link_out_t linkOut,
  output logic [7:0] ctrlView,
  output logic [7:0] flagsView,
  output logic [7:0] rxView,
  output logic irq
);

  localparam logic [7:0] CtrlRst = `SRU_CTL_RESET;

  sru_pkg::sru_chan_t s_q;
  sru_pkg::sru_chan_t s_d;

  logic sckS;
  logic mosiS;
  logic misoS;
  logic ssNS;
  logic lead;
  logic trail;
  logic busy;
  logic rxIn;
  logic doneEvt;
  logic wcolEvt;
  logic modfEvt;
  logic [7:0] nextShift;

  assign sckS = s_q.syncB[3];
  assign mosiS = s_q.syncB[2];
  assign misoS = s_q.syncB[1];
  assign ssNS = s_q.syncB[0];

  always_comb begin
    s_d = s_q;
    lead = 1'b0;
    trail = 1'b0;
    doneEvt = 1'b0;
    wcolEvt = 1'b0;
    modfEvt = 1'b0;
    nextShift = s_q.shifter;
    rxIn = s_q.master ? misoS : mosiS;
    busy = (s_q.mst == sru_pkg::SRU_RUN) || (s_q.bitCnt != 3'h0);

    // two-stage synchronisers; only the second stage is read
    s_d.syncA = {linkIn.sck, linkIn.mosi, linkIn.miso, linkIn.ssN};
    s_d.syncB = s_q.syncA;
    s_d.prevSck = sckS;

    // software control writes; reserved bits are dropped
    if (ctrlWr) begin
      s_d.irqEn = wdata[`SRU_CTL_IRQ_EN]; // RULE_01
      s_d.spiEn = wdata[`SRU_CTL_SPI_EN]; // RULE_02
      s_d.master = wdata[`SRU_CTL_MASTER]; // RULE_03
      s_d.cpol = wdata[`SRU_CTL_CPOL]; // RULE_04
      s_d.cpha = wdata[`SRU_CTL_CPHA]; // RULE_05
    end

    // edge sources: own divider in master role, the pin in slave role
    if (s_q.spiEn && s_q.master) begin
      if (s_q.mst == sru_pkg::SRU_RUN) begin
        if (s_q.divCnt == `SRU_HALF_PERIOD - 8'h01) begin
          s_d.divCnt = 8'h00;
          s_d.sckOut = ~s_q.sckOut;
          if (s_q.sckOut == s_q.cpol) begin
            lead = 1'b1;
          end else begin
            trail = 1'b1;
          end
        end else begin
          s_d.divCnt = s_q.divCnt + 8'h01;
        end
      end else begin
        s_d.sckOut = s_q.cpol; // RULE_04
        s_d.divCnt = 8'h00;
      end
    end else if (s_q.spiEn && !ssNS) begin
      // slave only moves while selected
      lead = (sckS != s_q.cpol) && (s_q.prevSck == s_q.cpol);
      trail = (sckS == s_q.cpol) && (s_q.prevSck != s_q.cpol);
    end else if (!s_q.spiEn || ssNS) begin
      // deselect or disable abandons any partial byte
      s_d.bitCnt = 3'h0;
      s_d.mst = sru_pkg::SRU_IDLE;
      s_d.sckOut = s_q.cpol;
    end

    // phase 0 samples on lead and shifts on trail; phase 1 changes on lead
    if (lead) begin
      if (!s_q.cpha) begin
        s_d.sampleBit = rxIn; // RULE_20
      end else begin
        s_d.outBit = s_q.shifter[7]; // RULE_20
      end
    end
    if (trail) begin
      if (!s_q.cpha) begin
        nextShift = {s_q.shifter[6:0], s_q.sampleBit}; // RULE_20
        s_d.outBit = s_q.shifter[6];
      end else begin
        nextShift = {s_q.shifter[6:0], rxIn}; // RULE_20
      end
      s_d.shifter = nextShift;
      s_d.bitCnt = s_q.bitCnt + 3'h1;
      if (s_q.bitCnt == `SRU_LAST_BIT) begin
        // eighth trailing edge leaves the clock at idle level
        doneEvt = 1'b1; // RULE_19
        s_d.bitCnt = 3'h0;
        s_d.mst = sru_pkg::SRU_IDLE;
      end
    end

    // between bytes the first data bit waits on the line
    if (!lead && !trail && s_q.bitCnt == 3'h0) begin
      s_d.outBit = s_q.shifter[7];
    end

    // transmit writes go straight into the shifter, no staging register
    if (dataWr) begin
      if (busy) begin
        wcolEvt = 1'b1; // RULE_18
      end else begin
        s_d.shifter = wdata; // RULE_09
        if (s_q.spiEn && s_q.master) begin
          // the same start clocks the next byte in
          s_d.mst = sru_pkg::SRU_RUN; // RULE_10 RULE_11
          s_d.divCnt = 8'h00;
        end
      end
    end

    // a master seeing its select low yields the bus
    if (s_q.spiEn && s_q.master && !ssNS) begin
      modfEvt = 1'b1; // RULE_17
      s_d.spiEn = 1'b0; // RULE_17
      s_d.master = 1'b0; // RULE_17
      s_d.mst = sru_pkg::SRU_IDLE;
      s_d.bitCnt = 3'h0;
      s_d.sckOut = s_q.cpol;
    end

    // completed byte moves to the read buffer unless done is still set with no flags read this cycle
    if (doneEvt) begin
      if (!s_q.done || flagsRd) begin
        s_d.rxBuf = nextShift; // RULE_14
      end
      // otherwise the new byte is dropped as an overrun RULE_15
    end

    // reading flags clears them, but a same-cycle event still lands
    if (flagsRd) begin
      s_d.done = 1'b0; // RULE_06
      s_d.write_collision_flag = 1'b0; // RULE_06
      s_d.mode_fault_flag = 1'b0; // RULE_06
    end
    if (doneEvt) begin
      s_d.done = 1'b1; // RULE_07 RULE_12
    end
    if (wcolEvt) begin
      s_d.write_collision_flag = 1'b1; // RULE_08
    end
    if (modfEvt) begin
      s_d.mode_fault_flag = 1'b1; // RULE_17
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_q <= '0;
      s_q.cpha <= CtrlRst[`SRU_CTL_CPHA]; // RULE_05
      s_q.spiEn <= CtrlRst[`SRU_CTL_SPI_EN]; // RULE_02
      s_q.syncA <= 4'hF;
      s_q.syncB <= 4'hF;
    end else begin
      s_q <= s_d;
    end
  end

  always_comb begin
    ctrlView = `SRU_ZERO_BYTE;
    ctrlView[`SRU_CTL_IRQ_EN] = s_q.irqEn;
    ctrlView[`SRU_CTL_SPI_EN] = s_q.spiEn;
    ctrlView[`SRU_CTL_MASTER] = s_q.master;
    ctrlView[`SRU_CTL_CPOL] = s_q.cpol;
    ctrlView[`SRU_CTL_CPHA] = s_q.cpha;
    flagsView = `SRU_ZERO_BYTE;
    flagsView[`SRU_FLG_DONE] = s_q.done;
    flagsView[`SRU_FLG_WRITE_COLLISION_FLAG] = s_q.write_collision_flag;
    flagsView[`SRU_FLG_MODE_FAULT_FLAG] = s_q.mode_fault_flag;
  end

  assign rxView = s_q.rxBuf; // RULE_13 RULE_14
  // held until a flags read clears the cause
  assign irq = s_q.irqEn && (s_q.done || s_q.mode_fault_flag); // RULE_01 RULE_21

  // pins float whenever the unit is off; a slave drives only when selected
  assign linkOut.sckOut = s_q.sckOut;
  assign linkOut.sckOeN = !(s_q.spiEn && s_q.master);
  assign linkOut.mosiOut = s_q.outBit;
  assign linkOut.mosiOeN = !(s_q.spiEn && s_q.master);
  assign linkOut.misoOut = s_q.outBit;
  assign linkOut.misoOeN = !(s_q.spiEn && !s_q.master && !ssNS);

endmodule : sru_channel

// Notes on behaviour
// RULE_01 - control bit 7 gates the interrupt request.
// RULE_02 - control bit 5 enables the unit; it resets to zero.
// RULE_03 - control bit 4 selects master when set, slave when clear.
// RULE_04 - control bit 3 sets master clock idle level.
// RULE_05 - control bit 2 is phase; resets to one; phase 0 needs select high per byte.
// RULE_06 - reading the flags register clears bits 7, 6 and 4.
// RULE_07 - flag bit 7 sets when a byte finishes and can raise interrupt.
// RULE_08 - flag bit 6 sets on a write collision until next flags read.
// RULE_09 - a transmit write loads the shifter directly, no transmit buffer.
// RULE_10 - in master role a transmit write starts sending the byte.
// RULE_11 - master write also starts reception; slave write only preloads.
// RULE_12 - byte completion sets flag bit 7 in both roles.
// RULE_13 - transmit shifter and receive buffer share one address.
// RULE_14 - reads return a receive buffer loaded after each completed byte.
// RULE_15 - a byte completing while flag bit 7 is still set is discarded.
// RULE_16 - two identical channels, 0 and 1, each with three registers.
// RULE_17 - master with select low: mode fault, drop enable and master, interrupt.
// RULE_18 - transmit write during a transfer is ignored and flags a collision.
// RULE_19 - master makes exactly eight clocks per byte then idles the clock.
// RULE_20 - phase 0 samples leading, changes trailing; phase 1 the reverse.
// RULE_21 - interrupt holds while enabled and done or fault flag set.
module sru_top (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  input wire sru_pkg::sru_link_in_t [1:0] linkIn,
  output sru_pkg::sru_link_out_t [1:0] linkOut,
  output logic [1:0] irq
);

  localparam logic [7:0] CtrlOff [2] = '{`SRU_CH0_CONTROL, `SRU_CH1_CONTROL};
  localparam logic [7:0] FlagsOff [2] = '{`SRU_CH0_FLAGS, `SRU_CH1_FLAGS};
  localparam logic [7:0] DataOff [2] = '{`SRU_CH0_DATA, `SRU_CH1_DATA};

  sru_pkg::sru_top_t s_q;
  sru_pkg::sru_top_t s_d;

  logic [1:0] ctrlWr;
  logic [1:0] dataWr;
  logic [1:0] flagsRd;
  logic [7:0] ctrlView [2];
  logic [7:0] flagsView [2];
  logic [7:0] rxView [2];

  // strobes per channel; unmapped offsets do nothing and read zero
  always_comb begin
    s_d = s_q;
    ctrlWr = 2'b00;
    dataWr = 2'b00;
    flagsRd = 2'b00;
    if (regRd) begin
      s_d.rdata = `SRU_ZERO_BYTE;
    end
    for (int i = 0; i < 2; i++) begin
      if (regAddr == CtrlOff[i]) begin
        ctrlWr[i] = regWr;
        if (regRd) begin
          s_d.rdata = ctrlView[i];
        end
      end else if (regAddr == FlagsOff[i]) begin
        flagsRd[i] = regRd; // RULE_06
        if (regRd) begin
          s_d.rdata = flagsView[i];
        end
      end else if (regAddr == DataOff[i]) begin
        dataWr[i] = regWr; // RULE_13
        if (regRd) begin
          s_d.rdata = rxView[i]; // RULE_13
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign regRdata = s_q.rdata;

  for (genvar g = 0; g < 2; g++) begin : gChan
    sru_channel uChan ( // RULE_16
      .clk(clk),
      .reset(reset),
      .ctrlWr(ctrlWr[g]),
      .dataWr(dataWr[g]),
      .flagsRd(flagsRd[g]),
      .wdata(regWdata),
      .linkIn(linkIn[g]),
      .linkOut(linkOut[g]),
      .ctrlView(ctrlView[g]),
      .flagsView(flagsView[g]),
      .rxView(rxView[g]),
      .irq(irq[g])
    );
  end

endmodule : sru_top

// ==== verif/sru_top_props.sv ====
// sru_top_props.sv: assertions on the sru_top register port and serial pins
// assumes: bound into sru_top, one clock domain
`timescale 1ns/10ps
`include "sru_consts.svh"
module sru_top_props (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdata,
  input wire sru_pkg::sru_link_in_t [1:0] linkIn,
  input wire sru_pkg::sru_link_out_t [1:0] linkOut,
  input wire logic [1:0] irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_rd(a);
    regRd && regAddr == a;
  endsequence
  sequence s_sck_hold;
    $stable(linkOut[0].sckOut) [*3];
  endsequence
  a_rdata_hold: assert property (
    !$past(regRd) |-> $stable(regRdata)) else $error("read data moved");
  a_unmapped_zero: assert property (
    regRd && !(regAddr inside {[8'hB6:8'hB8], [8'hBA:8'hBC]}) |=> regRdata == 8'h00)
    else $error("unmapped read not zero");
  a_ctl_reserved: assert property (
    regRd && regAddr[1:0] == 2'h2 |=> (regRdata & 8'h43) == 8'h00)
    else $error("control reserved bit set");
  a_flags_reserved: assert property (
    regRd && regAddr[1:0] == 2'h3 |=> (regRdata & 8'h2F) == 8'h00)
    else $error("flags reserved bit set");
  a_irq_read_clear: assert property (
    s_rd(`SRU_CH0_FLAGS) |=> !irq[0]) else $error("irq kept after flags read");
  a_irq_gate_off: assert property (
    s_rd(`SRU_CH0_CONTROL) ##1 !regRdata[7] |-> !irq[0]) else $error("irq while masked");
  a_role_drive_excl: assert property (
    (linkOut[0].sckOeN | linkOut[0].misoOeN) && (linkOut[1].sckOeN | linkOut[1].misoOeN))
    else $error("master and slave drive at once");
  a_sck_half_period: assert property (
    $changed(linkOut[0].sckOut) && !linkOut[0].sckOeN |=> s_sck_hold)
    else $error("serial clock half period short");
  a_mode_fault_flag_release: assert property (
    !linkIn[0].ssN [*6] |-> linkOut[0].sckOeN) else $error("master kept clock on fault");
endmodule : sru_top_props

bind sru_top sru_top_props u_sru_top_props (.clk(clk), .reset(reset), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
  .linkIn(linkIn), .linkOut(linkOut), .irq(irq));

// ==== verif/sru_spi_peer.sv ====
// sru_spi_peer.sv: behavioural spi slave facing the master channel
// assumes: sck and mosi come straight from the master's pin drivers
`timescale 1ns/10ps
module sru_spi_peer (
  input wire logic sck,
  input wire logic mosi,
  input wire logic selN,
  input wire logic cpol,
  input wire logic cpha,
  input wire logic [7:0] txByte,
  output logic miso,
  output logic [7:0] rxByte
);
  logic [7:0] sh;
  initial miso = 1'b1;
  // phase 0 has no launching edge for bit 7, so selection puts it out
  always @(negedge selN) begin
    sh = txByte;
    miso = txByte[7];
  end
  // a released line shows the inverse so a stale bit cannot pass
  always @(posedge selN) miso = ~miso;
  always @(sck) begin
    if (!selN && ((sck != cpol) ^ cpha)) begin
      rxByte = {rxByte[6:0], mosi};
    end else if (!selN && cpha) begin
      miso = sh[7];
      sh = sh << 1;
    end else if (!selN) begin
      sh = sh << 1;
      miso = sh[7];
    end
  end
endmodule : sru_spi_peer

// ==== verif/sru_top_test.sv ====
// sru_top_test.sv: register and link scenarios for the two-channel spi unit
// assumes: channel 0 masters the peer model, channel 1 listens as a slave
`timescale 1ns/10ps
`include "sru_consts.svh"
`define CHK(g, e) begin cmpCount++; if ((g) !== (e)) begin errCount++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module sru_top_test;
  logic clk, reset, regWr, regRd, selN, mfN, cpol, cpha, peerMiso;
  logic [7:0] regAddr, regWdata, regRdata, peerTx, peerRx;
  logic [1:0] irq;
  int errCount, cmpCount, edges;
  sru_pkg::sru_link_in_t [1:0] lnkIn;
  sru_pkg::sru_link_out_t [1:0] lnkOut;
  // channel 1 sits on the master's own pins as a second slave
  // one driver for the whole pin array; element 1 is the upper half
  assign lnkIn = {{lnkOut[0].sckOut, lnkOut[0].mosiOut, 1'b1, selN},
    {lnkOut[0].sckOut, lnkOut[1].misoOut, peerMiso, mfN}};
  always @(lnkOut[0].sckOut) edges++;
  sru_top u_sru_top (.clk(clk), .reset(reset), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .linkIn(lnkIn), .linkOut(lnkOut),
    .irq(irq));
  sru_spi_peer u_sru_spi_peer (.sck(lnkOut[0].sckOut), .mosi(lnkOut[0].mosiOut),
    .selN(selN), .cpol(cpol), .cpha(cpha), .txByte(peerTx), .miso(peerMiso),
    .rxByte(peerRx));
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    `CHK(regRdata, e)
  endtask : rd
  // col writes again mid-byte, which must be refused
  task automatic xfer(input logic [7:0] d, input logic col);
    wr(`SRU_CH0_DATA, d);
    #1;
    edges = 0;
    repeat (30) @(posedge clk);
    if (col) wr(`SRU_CH0_DATA, ~d);
    repeat (90) @(posedge clk);
    #1;
    `CHK(edges, 16)
  endtask : xfer
  task automatic tReset();
    rd(`SRU_CH0_CONTROL, `SRU_CTL_RESET);
    rd(`SRU_CH1_CONTROL, `SRU_CTL_RESET);
    wr(`SRU_CH0_FLAGS, 8'hFF);
    rd(`SRU_CH0_FLAGS, 8'h00);
    wr(`SRU_CH0_CONTROL, 8'h43);
    rd(`SRU_CH0_CONTROL, 8'h00);
    rd(8'hB9, 8'h00);
  endtask : tReset
  task automatic tModes();
    logic [7:0] d;
    for (int m = 0; m < 4; m++) begin
      {cpol, cpha} = m[1:0];
      peerTx = 8'hC3 ^ m[7:0];
      d = 8'h5A + m[7:0];
      wr(`SRU_CH1_CONTROL, {4'hA, cpol, cpha, 2'h0});
      wr(`SRU_CH0_CONTROL, {4'hB, cpol, cpha, 2'h0});
      rd(`SRU_CH0_CONTROL, {4'hB, cpol, cpha, 2'h0});
      `CHK(lnkOut[0].sckOut, cpol)
      wr(`SRU_CH1_DATA, ~d);
      rd(`SRU_CH1_FLAGS, 8'h00);
      selN <= 1'b0;
      xfer(d, 1'b1);
      selN <= 1'b1;
      `CHK(lnkOut[0].sckOut, cpol)
      `CHK(irq, 2'h3)
      `CHK(peerRx, d)
      rd(`SRU_CH0_DATA, peerTx);
      rd(`SRU_CH1_DATA, d);
      rd(`SRU_CH0_FLAGS, 8'hC0);
      rd(`SRU_CH0_FLAGS, 8'h00);
      `CHK(irq[0], 1'b0)
      rd(`SRU_CH1_FLAGS, 8'h80);
    end
  endtask : tModes
  task automatic tOverrun();
    cpol = 1'b0;
    cpha = 1'b1;
    peerTx = 8'h96;
    wr(`SRU_CH0_CONTROL, 8'h34);
    selN <= 1'b0;
    xfer(8'h0F, 1'b0);
    `CHK(irq[0], 1'b0)
    selN <= 1'b1;
    peerTx = 8'h69;
    repeat (2) @(posedge clk);
    selN <= 1'b0;
    xfer(8'hF0, 1'b0);
    selN <= 1'b1;
    rd(`SRU_CH0_DATA, 8'h96);
    rd(`SRU_CH0_FLAGS, 8'h80);
  endtask : tOverrun
  task automatic tModf();
    wr(`SRU_CH0_CONTROL, 8'hB4);
    mfN <= 1'b0;
    repeat (8) @(posedge clk);
    #1;
    `CHK(irq[0], 1'b1)
    rd(`SRU_CH0_CONTROL, 8'h84);
    mfN <= 1'b1;
    rd(`SRU_CH0_FLAGS, 8'h10);
  endtask : tModf
  task automatic stopTest();
    $display("mismatches %0d of %0d compares", errCount, cmpCount);
    if (errCount == 0 && cmpCount > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stopTest
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    {reset, selN, mfN, cpha} = 4'hF;
    {regWr, regRd, cpol} = 3'h0;
    {regAddr, regWdata, peerTx} = 24'h000000;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    tReset();
    tModes();
    tOverrun();
    tModf();
    stopTest();
  end
  // the scenarios need well under 3000 cycles; this is ten times that
  initial begin
    #240us;
    errCount++;
    stopTest();
  end
endmodule : sru_top_test
